// ===== src/ecc_map.svh
// register offsets, field positions, reset values and timing counts
`ifndef ECC_MAP_SVH
`define ECC_MAP_SVH
// command byte fields
`define ECC_CMD_ZERO_EN      0
`define ECC_CMD_EXT_RISE_EN  1
`define ECC_CMD_LOAD         2
`define ECC_CMD_EXT_FALL_EN  3
`define ECC_CMD_WRITE        6
`define ECC_CMD_REG_MODE     7
// condition byte fields
`define ECC_ST_ZERO_VAL      0
`define ECC_ST_EXT_VAL       1
`define ECC_ST_LOAD_ACK      2
`define ECC_ST_UNDERFLOW     3
`define ECC_ST_OVERFLOW      4
`define ECC_ST_BIT_FIVE      5
`define ECC_ST_BIT_SIX       6
`define ECC_ST_REG_MODE      7
// feature register and its fields
`define ECC_REG_FEATURE      6'h20
`define ECC_FEATURE_RESET    16'h2200
`define ECC_FEAT_MAP_LO      2
`define ECC_FEAT_FUNC_LO     4
// counter thresholds for the wrap flags
`define ECC_OVF_CLEAR_FROM   16'h5555
`define ECC_UNF_CLEAR_FROM   16'haaaa
// period time base
`define ECC_PERIOD_STEP_NS   200
`define ECC_CLOCK_NS         50
`define ECC_PERIOD_DIV       (`ECC_PERIOD_STEP_NS / `ECC_CLOCK_NS)
`endif

// ===== src/ecc_pkg.sv
// types shared by the encoder counter control logic
`default_nettype none
package ecc_pkg;
  typedef enum logic [1:0] {
    ECC_FUNC_LATCH  = 2'b01,
    ECC_FUNC_PERIOD = 2'b10
  } ecc_func_t;

  // general purpose register words live in an array of the module; only the feature word is in this struct
  typedef struct packed {
    logic [7:0]  cmd_prev;
    logic [15:0] count;
    logic [15:0] latch_val;
    logic [23:0] period;
    logic [23:0] period_run;
    logic [1:0]  div;
    logic        period_ok;
    logic        zero_val;
    logic        ext_val;
    logic        ovf;
    logic        unf;
    logic        load_ack;
    logic [2:0]  c_sync;
    logic [2:0]  l_sync;
    logic [2:0]  a_sync;
    logic [2:0]  s_sync;
    logic        c_lvl;
    logic        l_lvl;
    logic        a_lvl;
    logic        s_lvl;
    logic [15:0] feature;
    logic [7:0]  st_out;
    logic [15:0] word_out;
    logic [7:0]  b4_out;
  } ecc_state_t;
endpackage
`default_nettype wire

// ===== src/ecc_control.sv
// control and status byte logic of the incremental encoder counter
// Summary of operation
// R1: control bit 7 selects register mode
// R2: register read returns value unchanged
// R3: register write stores output word
// R4: write ack echoes address with bit 7
// R5: bits 0..5 address one of 64
// R6: status byte first, word follows
// R7: load counter on rising load bit
// R8: status bit 2 acknowledges counter load
// R9: armed zero latch keeps first C pulse
// R10: zero latch beats external latch
// R11: zero valid held while C high
// R12: first rising external edge latches
// R13: first falling external edge latches
// R14: rising enable beats falling enable
// R15: period of A in 200 ns steps
// R16: status bit 1 flags period data
// R17: status bit 1 shows external latch
// R18: controller toggles enable to re-arm
// R19: status bit 0, re-arm by toggling
// R20: overflow flag set and cleared
// R21: underflow flag set and cleared
// R22: status input drives bit 5
// R23: feature field selects bit 1 function
// R24: feature field maps status input
// R25: idle data word is live count
// R26: bit 7 zero in process mode
`include "ecc_map.svh"
`default_nettype none
module ecc_control (
  input  wire logic        clock,
  input  wire logic        resetn,
  input  wire logic [7:0]  command_byte,
  input  wire logic [15:0] data_out_word,
  input  wire logic        count_up,
  input  wire logic        count_down,
  input  wire logic        zero_pulse_in,
  input  wire logic        ext_latch_in,
  input  wire logic        encoder_a_in,
  input  wire logic        status_in,
  output logic [7:0]       condition_byte,
  output logic [15:0]      data_in_word,
  output logic [7:0]       data_in_byte4
);
  // ************************************************************
  // state
  // ************************************************************
  ecc_pkg::ecc_state_t state_reg;
  ecc_pkg::ecc_state_t state_next;
  // general purpose registers; feature register held in state
  logic [15:0] regs_reg [0:63];

  // three-stage sampling; change accepted when last two agree
  function automatic logic filt(input logic [2:0] s, input logic old);
    filt = (s[1] == s[2]) ? s[2] : old;
  endfunction

  logic [5:0]  addr;
  logic        reg_mode;
  logic        wr;
  logic        func_period;
  logic [1:0]  map;
  logic        c_new;
  logic        l_new;
  logic        a_new;
  logic        s_new;
  logic [15:0] rd_val;

  assign addr        = command_byte[5:0]; // R5
  assign reg_mode    = command_byte[`ECC_CMD_REG_MODE]; // R1
  assign wr          = command_byte[`ECC_CMD_WRITE];
  assign func_period = (state_reg.feature[`ECC_FEAT_FUNC_LO +: 3]
                        == 3'h1); // R23
  assign map         = state_reg.feature[`ECC_FEAT_MAP_LO +: 2];
  assign c_new = filt(state_reg.c_sync, state_reg.c_lvl);
  assign l_new = filt(state_reg.l_sync, state_reg.l_lvl);
  assign a_new = filt(state_reg.a_sync, state_reg.a_lvl);
  assign s_new = filt(state_reg.s_sync, state_reg.s_lvl);
  assign rd_val = (addr == `ECC_REG_FEATURE) ? state_reg.feature
                                             : regs_reg[addr];

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [15:0] nxt;
    logic        l_rise;
    logic        l_fall;
    logic [7:0]  st;
    nxt = state_reg.count;
    l_rise = l_new & ~state_reg.l_lvl;
    l_fall = ~l_new & state_reg.l_lvl;
    st = 8'h00;
    state_next = state_reg;
    state_next.cmd_prev = command_byte;
    state_next.c_sync = {state_reg.c_sync[1:0], zero_pulse_in};
    state_next.l_sync = {state_reg.l_sync[1:0], ext_latch_in};
    state_next.a_sync = {state_reg.a_sync[1:0], encoder_a_in};
    state_next.s_sync = {state_reg.s_sync[1:0], status_in};
    state_next.c_lvl = c_new;
    state_next.l_lvl = l_new;
    state_next.a_lvl = a_new;
    state_next.s_lvl = s_new;
    // counter and wrap flags
    if (count_up && !count_down) begin
      nxt = state_reg.count + 16'h0001;
      if (state_reg.count == 16'hffff) begin
        state_next.ovf = 1'b1; // R20
        state_next.unf = 1'b0; // R21
      end else if (state_reg.count == `ECC_OVF_CLEAR_FROM) begin
        state_next.ovf = 1'b0; // R20
      end
    end else if (count_down && !count_up) begin
      nxt = state_reg.count - 16'h0001;
      if (state_reg.count == 16'h0000) begin
        state_next.unf = 1'b1; // R21
        state_next.ovf = 1'b0; // R20
      end else if (state_reg.count == `ECC_UNF_CLEAR_FROM) begin
        state_next.unf = 1'b0; // R21
      end
    end
    // load takes effect only in process mode, on the rising load bit
    state_next.load_ack = ~reg_mode & command_byte[`ECC_CMD_LOAD]
                          & (state_reg.load_ack
                          | ~state_reg.cmd_prev[`ECC_CMD_LOAD]); // R8
    if (!reg_mode && command_byte[`ECC_CMD_LOAD]
        && !state_reg.cmd_prev[`ECC_CMD_LOAD]) begin
      nxt = data_out_word; // R7
    end
    state_next.count = nxt;
    // latches; valid flags clear while enable is off, the zero flag only once C is also low
    // in register mode bits 0..5 are an address, so latches stay frozen;
    // a pin edge during a register access is therefore not caught
    if (!reg_mode) begin
      if (!command_byte[`ECC_CMD_ZERO_EN] && !c_new) begin
        state_next.zero_val = 1'b0; // R11 R19
      end
      if (!command_byte[`ECC_CMD_EXT_RISE_EN]
          && !command_byte[`ECC_CMD_EXT_FALL_EN]) begin
        state_next.ext_val = 1'b0; // R18
      end
      if (command_byte[`ECC_CMD_ZERO_EN] && !state_reg.zero_val
          && c_new && !state_reg.c_lvl) begin
        state_next.zero_val = 1'b1; // R9
        state_next.latch_val = state_reg.count;
      end else if (!func_period && !state_reg.ext_val
                   && !command_byte[`ECC_CMD_ZERO_EN]) begin // R10
        if (command_byte[`ECC_CMD_EXT_RISE_EN]) begin
          if (l_rise) begin
            state_next.ext_val = 1'b1; // R12 R14
            state_next.latch_val = state_reg.count;
          end
        end else if (command_byte[`ECC_CMD_EXT_FALL_EN] && l_fall) begin
          state_next.ext_val = 1'b1; // R13
          state_next.latch_val = state_reg.count;
        end
      end
    end
    // period timer in 200 ns steps
    if (state_reg.div == 2'(`ECC_PERIOD_DIV - 1)) begin
      state_next.div = 2'h0;
      if (state_reg.period_run != 24'hffffff) begin
        state_next.period_run = state_reg.period_run + 24'h000001;
      end
    end else begin
      state_next.div = state_reg.div + 2'h1;
    end
    if (a_new && !state_reg.a_lvl) begin
      // the step that completes at this edge belongs to this period
      state_next.period = state_next.period_run; // R15
      state_next.period_run = 24'h000000;
      state_next.div = 2'h0;
      state_next.period_ok = 1'b1;
    end
    // register access
    if (reg_mode && wr && addr == `ECC_REG_FEATURE) begin
      state_next.feature = data_out_word; // R3
    end
    // outputs
    state_next.word_out = state_reg.count; // R25
    state_next.b4_out = 8'h00;
    if (reg_mode) begin
      st = wr ? {1'b1, 1'b0, addr} : command_byte; // R4
      state_next.word_out = wr ? 16'h0000 : rd_val; // R2 R6
    end else begin
      st[`ECC_ST_ZERO_VAL] = state_reg.zero_val; // R19
      st[`ECC_ST_LOAD_ACK] = state_reg.load_ack;
      st[`ECC_ST_UNDERFLOW] = state_reg.unf;
      st[`ECC_ST_OVERFLOW] = state_reg.ovf;
      st[`ECC_ST_BIT_FIVE] = ~state_reg.s_lvl; // R22 R24
      if (map[1]) begin
        st[`ECC_ST_BIT_SIX] = map[0] ? state_reg.s_lvl
                                     : ~state_reg.s_lvl; // R24
      end
      st[`ECC_ST_REG_MODE] = 1'b0; // R26
      if (state_reg.zero_val) begin
        state_next.word_out = state_reg.latch_val;
      end else if (func_period) begin
        if (command_byte[`ECC_CMD_EXT_RISE_EN] && state_reg.period_ok) begin
          st[`ECC_ST_EXT_VAL] = 1'b1; // R16
          state_next.word_out = state_reg.period[15:0]; // R15
          state_next.b4_out = state_reg.period[23:16];
        end
      end else if (state_reg.ext_val) begin
        st[`ECC_ST_EXT_VAL] = 1'b1; // R17
        state_next.word_out = state_reg.latch_val;
      end
    end
    state_next.st_out = st;
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      state_reg <= '0;
      state_reg.feature <= `ECC_FEATURE_RESET;
      // status pin idles high; start there so no false status shows
      state_reg.s_sync <= 3'h7;
      state_reg.s_lvl <= 1'h1;
    end else begin
      state_reg <= state_next;
    end
  end

  // plain storage, no reset needed for the word array
  always_ff @(posedge clock) begin
    if (reg_mode && wr && addr != `ECC_REG_FEATURE) begin
      regs_reg[addr] <= data_out_word; // R3
    end
  end

  assign condition_byte = state_reg.st_out;
  assign data_in_word   = state_reg.word_out;
  assign data_in_byte4  = state_reg.b4_out;
endmodule
`default_nettype wire

// ===== testbench/ecc_chk.sv
// assertion checker for the control and status byte logic
`default_nettype none
module ecc_chk (
  input wire logic        clock,
  input wire logic        resetn,
  input wire logic [7:0]  command_byte,
  input wire logic [15:0] data_out_word,
  input wire logic        zero_pulse_in,
  input wire logic        status_in,
  input wire logic [7:0]  condition_byte,
  input wire logic [15:0] data_in_word
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  // ********
  // byte pair sequences
  // ********
  sequence s_write;
    command_byte[7:6] == 2'b11;
  endsequence
  sequence s_read_same;
    command_byte[7:6] == 2'b10
      && command_byte[5:0] == $past(command_byte[5:0]);
  endsequence
  sequence s_load_rise;
    !command_byte[7] && $rose(command_byte[2])
      ##1 !command_byte[7] && command_byte[2];
  endsequence
  a_read_echo: assert property (
    command_byte[7:6] == 2'b10 |=> condition_byte == $past(command_byte))
    else $error("read echo wrong");
  a_write_ack: assert property (
    s_write |=> condition_byte == {2'b10, $past(command_byte[5:0])})
    else $error("write ack wrong");
  a_write_read: assert property (
    s_write ##1 s_read_same |=> data_in_word == $past(data_out_word, 2))
    else $error("write then read wrong");
  a_proc_bit7: assert property (
    !command_byte[7] |=> !condition_byte[7])
    else $error("mode bit set in process mode");
  a_load_ack: assert property (
    s_load_rise |=> condition_byte[2])
    else $error("load not acknowledged");
  a_load_word: assert property (
    s_load_rise |=> (condition_byte[1:0] == 2'b00
      |-> data_in_word == $past(data_out_word, 2)))
    else $error("loaded word not shown");
  a_wrap_excl: assert property (
    !$past(command_byte[7]) |-> condition_byte[4:3] != 2'b11)
    else $error("both wrap flags set");
  a_zero_hold: assert property (
    zero_pulse_in[*5] ##0 (!command_byte[7])[*2] ##0 condition_byte[0]
      |=> condition_byte[0])
    else $error("zero flag dropped while C high");
  a_status_five: assert property (
    (!status_in)[*6] ##0 (!command_byte[7])[*2] |=> condition_byte[5])
    else $error("status bit five wrong");
endmodule
`default_nettype wire

// ===== testbench/ecc_coupler.sv
// coupler model driving the command byte and output word
`default_nettype none
module ecc_coupler (
  input  wire logic   clock,
  output logic [7:0]  command_byte,
  output logic [15:0] data_out_word
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    command_byte = 8'h00;
    data_out_word = 16'h0000;
  end
  // one byte pair per cycle, mode bit and word sent together
  task automatic send(input logic [7:0] c, input logic [15:0] d);
    @(posedge clock);
    #1;
    command_byte = c;
    data_out_word = d;
  endtask
  // enable must drop for a cycle before it arms again
  task automatic rearm(input logic [7:0] c, input logic [7:0] m);
    send(c & ~m, 16'h0000);
    send(c, 16'h0000);
  endtask
endmodule
`default_nettype wire

// ===== testbench/tb_top.sv
// testbench for the control and status byte logic
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock = 1'b0;
  logic        resetn = 1'b0;
  logic [7:0]  command_byte;
  logic [15:0] data_out_word;
  logic        count_up = 1'b0;
  logic        count_down = 1'b0;
  logic        zero_pulse_in = 1'b0;
  logic        ext_latch_in = 1'b0;
  logic        encoder_a_in = 1'b0;
  logic        status_in = 1'b1;
  logic [7:0]  condition_byte;
  logic [15:0] data_in_word;
  logic [7:0]  data_in_byte4;
  int          n_fail = 0;
  int          checked = 0;
  int          cycles = 0;
  always #25 clock = ~clock;
  ecc_coupler P (.clock(clock), .command_byte(command_byte),
    .data_out_word(data_out_word));
  ecc_control DUT (.clock(clock), .resetn(resetn),
    .command_byte(command_byte), .data_out_word(data_out_word),
    .count_up(count_up), .count_down(count_down),
    .zero_pulse_in(zero_pulse_in), .ext_latch_in(ext_latch_in),
    .encoder_a_in(encoder_a_in), .status_in(status_in),
    .condition_byte(condition_byte), .data_in_word(data_in_word),
    .data_in_byte4(data_in_byte4));
  // ********
  // helpers
  // ********
  task automatic conclude();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] got, exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  // pins pass three sync stages, so hold each level eight cycles
  task automatic pin(ref logic s, input logic v);
    s = v;
    tick(8);
  endtask
  task automatic cnt(input logic up);
    count_up = up;
    count_down = !up;
    tick(1);
    count_up = 1'b0;
    count_down = 1'b0;
    tick(2);
  endtask
  task automatic ld(input logic [15:0] v);
    P.send(8'h00, v);
    P.send(8'h04, v);
    tick(3);
    chk("load word", data_in_word, v);
    chk("load ack", condition_byte[2], 1'b1);
    chk("mode bit", condition_byte[7], 1'b0);
  endtask
  task automatic rw(input logic [5:0] a, input logic [15:0] d);
    P.send({2'b11, a}, d);
    tick(1);
    chk("write ack", condition_byte, {2'b10, a});
    P.send({2'b10, a}, 16'h0000);
    tick(1);
    chk("read echo", condition_byte, {2'b10, a});
    chk("read data", data_in_word, d);
    tick(1);
    chk("read again", data_in_word, d);
  endtask
  task automatic feat(input logic [15:0] v, input logic [7:0] c);
    rw(6'h20, v);
    P.send(c, 16'h0000);
    tick(1);
  endtask
  // ********
  // scenarios
  // ********
  task automatic t_reg();
    rw(6'h1f, 16'h1235);
    rw(6'h3f, 16'hbeef);
    rw(6'h00, 16'h8001);
    P.send(8'h9f, 16'h0000);
    tick(1);
    chk("index kept", data_in_word, 16'h1235);
    $display("register test done");
  endtask
  task automatic t_count();
    ld(16'h0000);
    cnt(1'b0);
    chk("under set", condition_byte[4:3], 2'b01);
    ld(16'haaaa);
    cnt(1'b0);
    chk("under clear", condition_byte[4:3], 2'b00);
    ld(16'hffff);
    cnt(1'b1);
    chk("wrap word", data_in_word, 16'h0000);
    chk("over set", condition_byte[4:3], 2'b10);
    cnt(1'b0);
    chk("over by under", condition_byte[4:3], 2'b01);
    cnt(1'b1);
    chk("under by over", condition_byte[4:3], 2'b10);
    ld(16'h5555);
    cnt(1'b1);
    chk("over clear", condition_byte[4:3], 2'b00);
    $display("counter test done");
  endtask
  task automatic t_zero();
    ld(16'h1234);
    P.send(8'h01, 16'h0000);
    pin(zero_pulse_in, 1'b1);
    pin(zero_pulse_in, 1'b0);
    chk("zero flag", condition_byte[1:0], 2'b01);
    chk("zero value", data_in_word, 16'h1234);
    cnt(1'b1);
    pin(zero_pulse_in, 1'b1);
    chk("zero kept", data_in_word, 16'h1234);
    P.send(8'h00, 16'h0000);
    tick(8);
    chk("zero held", condition_byte[0], 1'b1);
    pin(zero_pulse_in, 1'b0);
    chk("zero clear", condition_byte[0], 1'b0);
    chk("live count", data_in_word, 16'h1235);
    P.send(8'h03, 16'h0000);
    pin(ext_latch_in, 1'b1);
    pin(ext_latch_in, 1'b0);
    chk("zero first", condition_byte[1], 1'b0);
    $display("zero latch test done");
  endtask
  task automatic t_ext();
    pin(ext_latch_in, 1'b1);
    P.send(8'h0a, 16'h0000);
    cnt(1'b1);
    pin(ext_latch_in, 1'b0);
    chk("fall ignored", condition_byte[1], 1'b0);
    cnt(1'b1);
    pin(ext_latch_in, 1'b1);
    chk("rise flag", condition_byte[1], 1'b1);
    chk("rise value", data_in_word, 16'h1237);
    cnt(1'b1);
    pin(ext_latch_in, 1'b0);
    pin(ext_latch_in, 1'b1);
    chk("rise kept", data_in_word, 16'h1237);
    P.rearm(8'h08, 8'h08);
    cnt(1'b1);
    pin(ext_latch_in, 1'b0);
    chk("fall value", data_in_word, 16'h1239);
    $display("external latch test done");
  endtask
  task automatic t_stat();
    pin(status_in, 1'b0);
    chk("status map0", condition_byte[6:5], 2'b01);
    feat(16'h2208, 8'h00);
    chk("status map2", condition_byte[6:5], 2'b11);
    feat(16'h220c, 8'h00);
    chk("status map3", condition_byte[6:5], 2'b01);
    pin(status_in, 1'b1);
    chk("status idle", condition_byte[6:5], 2'b10);
    feat(16'h2210, 8'h02);
    repeat (3) begin
      pin(encoder_a_in, 1'b1);
      pin(encoder_a_in, 1'b0);
    end
    chk("period flag", condition_byte[1], 1'b1);
    chk("period", {data_in_byte4, data_in_word}, 24'd4);
    $display("status and period test done");
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      n_fail++;
      conclude();
    end
  end
  initial begin
    repeat (6) @(posedge clock);
    #1;
    resetn = 1'b1;
    t_reg();
    t_count();
    t_zero();
    t_ext();
    t_stat();
    conclude();
  end
endmodule
bind ecc_control ecc_chk u_chk (.clock(clock), .resetn(resetn),
  .command_byte(command_byte), .data_out_word(data_out_word),
  .zero_pulse_in(zero_pulse_in), .status_in(status_in),
  .condition_byte(condition_byte), .data_in_word(data_in_word));
`default_nettype wire
